// ---- hw/abt_master.sv ----
`timescale 1ns/1ps
// Contract
// - error termination, then error and halt released: take error trap
// - retry released in proper order: rerun the same bus cycle
// - retry released in wrong order: illegal sequence, vector zero exception
// - halt still held after normal end: next cycle is stretched
// - error still held when next cycle starts: that cycle errors
// - address strobe opens each cycle; write strobes mark valid data
// - no limit on acknowledge wait; wait cycles added one clock each
// - write: read-write line goes low after strobe, before data drive
// - write: byte strobes asserted only after data is on the bus
// - late error must come within its bound, else erratic behaviour
// - no termination seen: hold in wait state, add whole clocks
// - each termination input passes a synchroniser before use
module abt_master #(
    parameter bit LATE_TERM = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire abt_pkg::abt_req_t req,
    output logic done_pulse,
    output logic error_pulse,
    output logic illegal_pulse,
    output logic [abt_pkg::DATA_W-1:0] rdata,
    output logic address_strobe_n,
    output logic upper_byte_strobe_n,
    output logic lower_byte_strobe_n,
    output logic read_write_n,
    output logic [abt_pkg::ADDR_W-1:0] addr_out,
    output logic [abt_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [abt_pkg::DATA_W-1:0] data_in,
    input wire logic transfer_acknowledge_n,
    input wire logic bus_error_input_n,
    input wire logic halt_n
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    abt_pkg::abt_term_t term_s;
    abt_sync #(.WIDTH(abt_pkg::TERM_W)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .din({~transfer_acknowledge_n, ~bus_error_input_n, ~halt_n}),
        .dout(term_s)
    );

    // ----------------------------------------------------------------
    // state and held request
    // ----------------------------------------------------------------
    abt_pkg::abt_state_t state_reg, state_next;
    abt_pkg::abt_req_t cur_reg, cur_next;
    logic err_gone_reg, err_gone_next;
    logic done_next, error_next, illegal_next;

    // halt held after the previous cycle keeps the bus quiet
    assign req_ready = (state_reg == abt_pkg::ST_IDLE) && !term_s.halt;

    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        err_gone_next = err_gone_reg;
        done_next = 1'h0;
        error_next = 1'h0;
        illegal_next = 1'h0;
        case (state_reg)
            abt_pkg::ST_IDLE: begin
                // acknowledge is not looked at here
                if (req_valid && req_ready) begin
                    cur_next = req;
                    state_next = abt_pkg::ST_ADDR;
                end
            end
            abt_pkg::ST_ADDR: begin
                state_next = abt_pkg::ST_STROBE;
            end
            abt_pkg::ST_STROBE: begin
                state_next = cur_reg.write ? abt_pkg::ST_RWLOW : abt_pkg::ST_WAIT;
            end
            abt_pkg::ST_RWLOW: begin
                state_next = abt_pkg::ST_DRIVE;
            end
            abt_pkg::ST_DRIVE: begin
                state_next = abt_pkg::ST_WAIT;
            end
            abt_pkg::ST_WAIT: begin
                // error wins over acknowledge; leftover error ends this cycle too
                if (term_s.bus_err && term_s.halt) begin
                    err_gone_next = 1'h0;
                    state_next = abt_pkg::ST_RETRY;
                end else if (term_s.bus_err) begin
                    state_next = abt_pkg::ST_ERR;
                end else if (term_s.ack) begin
                    state_next = abt_pkg::ST_LATCH;
                end else begin
                    state_next = abt_pkg::ST_WAIT;
                end
            end
            abt_pkg::ST_LATCH: begin
                // late error seen one clock after the acknowledge
                if (LATE_TERM && term_s.bus_err && term_s.halt) begin
                    err_gone_next = 1'h0;
                    state_next = abt_pkg::ST_RETRY;
                end else if (LATE_TERM && term_s.bus_err) begin
                    state_next = abt_pkg::ST_ERR;
                end else begin
                    done_next = 1'h1;
                    state_next = abt_pkg::ST_IDLE;
                end
            end
            abt_pkg::ST_ERR: begin
                if (!term_s.bus_err && !term_s.halt) begin
                    error_next = 1'h1;
                    state_next = abt_pkg::ST_IDLE;
                end
            end
            abt_pkg::ST_RETRY: begin
                if (!term_s.halt) begin
                    if (!term_s.bus_err && err_gone_reg) begin
                        state_next = abt_pkg::ST_ADDR;
                    end else begin
                        illegal_next = 1'h1;
                        state_next = abt_pkg::ST_IDLE;
                    end
                end else if (!term_s.bus_err) begin
                    err_gone_next = 1'h1;
                end
            end
            default: begin
                state_next = abt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= abt_pkg::ST_IDLE;
            cur_reg <= '0;
            err_gone_reg <= 1'h0;
            done_pulse <= 1'h0;
            error_pulse <= 1'h0;
            illegal_pulse <= 1'h0;
        end else if (ce) begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            err_gone_reg <= err_gone_next;
            done_pulse <= done_next;
            error_pulse <= error_next;
            illegal_pulse <= illegal_next;
        end
    end

    // ----------------------------------------------------------------
    // pin drive, registered from the next state
    // ----------------------------------------------------------------
    logic as_next, ube_next, lbe_next, rw_next, oe_next;
    logic [abt_pkg::ADDR_W-1:0] addr_next;
    logic [abt_pkg::DATA_W-1:0] dout_next, rdata_next;
    logic in_cycle, strobe_on;

    always_comb begin
        in_cycle = state_next inside {abt_pkg::ST_STROBE, abt_pkg::ST_RWLOW,
            abt_pkg::ST_DRIVE, abt_pkg::ST_WAIT, abt_pkg::ST_LATCH};
        // write strobes wait until data has been driven for a clock
        strobe_on = cur_next.write ?
            (state_next inside {abt_pkg::ST_WAIT, abt_pkg::ST_LATCH}) : in_cycle;
        as_next = !in_cycle;
        ube_next = !(strobe_on && cur_next.upper);
        lbe_next = !(strobe_on && cur_next.lower);
        rw_next = !(cur_next.write && in_cycle && state_next != abt_pkg::ST_STROBE);
        oe_next = cur_next.write &&
            (state_next inside {abt_pkg::ST_DRIVE, abt_pkg::ST_WAIT, abt_pkg::ST_LATCH});
        addr_next = (state_next == abt_pkg::ST_IDLE) ? addr_out : cur_next.addr;
        dout_next = cur_next.wdata;
        // read data taken a clock after the acknowledge, allowing it to lead data
        rdata_next = (state_reg == abt_pkg::ST_LATCH && !cur_reg.write) ?
            data_in : rdata;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            address_strobe_n <= abt_pkg::STROBE_OFF;
            upper_byte_strobe_n <= abt_pkg::STROBE_OFF;
            lower_byte_strobe_n <= abt_pkg::STROBE_OFF;
            read_write_n <= abt_pkg::RW_READ;
            data_oe <= 1'h0;
            addr_out <= abt_pkg::ADDR_RST;
            data_out <= abt_pkg::DATA_RST;
            rdata <= abt_pkg::DATA_RST;
        end else if (ce) begin
            address_strobe_n <= as_next;
            upper_byte_strobe_n <= ube_next;
            lower_byte_strobe_n <= lbe_next;
            read_write_n <= rw_next;
            data_oe <= oe_next;
            addr_out <= addr_next;
            data_out <= dout_next;
            rdata <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic strobes_on;
    assign strobes_on = !upper_byte_strobe_n || !lower_byte_strobe_n;

    a_idle_quiet: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_IDLE && $past(state_reg) == abt_pkg::ST_IDLE
        |-> address_strobe_n && !strobes_on)
        else $error("strobe active while idle");
    a_as_opens: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_ADDR |=> !address_strobe_n ##1 !address_strobe_n)
        else $error("address strobe not asserted at cycle start");
    a_rw_before_data: assert property (@(posedge mclk iff ce) disable iff (rst)
        $rose(data_oe) |-> !read_write_n && $past(!read_write_n) && !address_strobe_n)
        else $error("data driven before read-write low");
    a_data_before_strobe: assert property (@(posedge mclk iff ce) disable iff (rst)
        !read_write_n && strobes_on |-> data_oe && $past(data_oe))
        else $error("write strobe before data valid");
    a_wait_holds: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_WAIT && !term_s.ack && !term_s.bus_err
        |=> state_reg == abt_pkg::ST_WAIT && !address_strobe_n)
        else $error("wait state left without termination");
    a_error_trap: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_ERR && !term_s.bus_err && !term_s.halt
        |=> error_pulse ##1 !error_pulse)
        else $error("bus error trap not reported");
    a_rerun_cycle: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_RETRY && err_gone_reg && !term_s.bus_err && !term_s.halt
        |=> state_reg == abt_pkg::ST_ADDR ##2 !address_strobe_n)
        else $error("retry did not rerun cycle");
    a_illegal_order: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_RETRY && !term_s.halt && (term_s.bus_err || !err_gone_reg)
        |=> illegal_pulse && state_reg == abt_pkg::ST_IDLE)
        else $error("illegal release order not flagged");
    a_halt_stretch: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_IDLE && term_s.halt |=> state_reg == abt_pkg::ST_IDLE)
        else $error("cycle started while halt held");
    a_leftover_error: assert property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_WAIT && term_s.bus_err && !term_s.halt
        |=> state_reg == abt_pkg::ST_ERR ##1 address_strobe_n)
        else $error("leftover bus error did not end cycle");
    a_sync_delay: assert property (@(posedge mclk iff ce) disable iff (rst)
        ##2 term_s.bus_err == $past(!bus_error_input_n, 2))
        else $error("synchroniser delay wrong");
    a_late_error: assert property (@(posedge mclk iff ce) disable iff (rst)
        LATE_TERM && state_reg == abt_pkg::ST_LATCH && term_s.bus_err && !term_s.halt
        |=> state_reg == abt_pkg::ST_ERR && !done_pulse)
        else $error("late bus error missed");

    c_read_done: cover property (@(posedge mclk iff ce) disable iff (rst)
        read_write_n && done_pulse);
    c_write_done: cover property (@(posedge mclk iff ce) disable iff (rst)
        cur_reg.write && done_pulse);
    c_rerun: cover property (@(posedge mclk iff ce) disable iff (rst)
        state_reg == abt_pkg::ST_RETRY ##1 state_reg == abt_pkg::ST_ADDR);
    c_trap: cover property (@(posedge mclk iff ce) disable iff (rst) error_pulse);

endmodule // abt_master

// ---- hw/abt_pkg.sv ----
package abt_pkg;

    // ----------------------------------------------------------------
    // bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int TERM_W = 3;

    // ----------------------------------------------------------------
    // values after reset (pins are active low, so 1 means negated)
    // ----------------------------------------------------------------
    localparam logic STROBE_OFF = 1'h1;
    localparam logic RW_READ = 1'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // ----------------------------------------------------------------
    // synchroniser depth in clock cycles
    // ----------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // bus master states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_ADDR   = 9'h002,
        ST_STROBE = 9'h004,
        ST_RWLOW  = 9'h008,
        ST_DRIVE  = 9'h010,
        ST_WAIT   = 9'h020,
        ST_LATCH  = 9'h040,
        ST_ERR    = 9'h080,
        ST_RETRY  = 9'h100
    } abt_state_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic upper;
        logic lower;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } abt_req_t;

    // termination inputs, active high after inversion
    typedef struct packed {
        logic ack;
        logic bus_err;
        logic halt;
    } abt_term_t;

endpackage

// ---- hw/abt_sync.sv ----
`timescale 1ns/1ps
module abt_sync #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ----------------------------------------------------------------
    // two flops per bit; the first is read only by the second
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic meta_next;
            logic sync_reg;
            logic sync_next;
            always_comb begin
                meta_next = ce ? din[i] : meta_reg;
                sync_next = ce ? meta_reg : sync_reg;
            end
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'h0;
                    sync_reg <= 1'h0;
                end else begin
                    meta_reg <= meta_next;
                    sync_reg <= sync_next;
                end
            end
            assign dout[i] = sync_reg;
        end
    endgenerate

endmodule // abt_sync

// ---- bench/abt_slave.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// slave and error-injecting memory model
// ----------------------------------------------------------------
module abt_slave (
    input wire logic mclk,
    input wire logic rst,
    input wire logic arm,
    input wire logic [2:0] mode,
    input wire logic [3:0] delay,
    input wire logic stall_halt,
    input wire logic stall_fault,
    input wire logic address_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic read_write_n,
    input wire logic [abt_pkg::ADDR_W-1:0] addr_out,
    input wire logic [abt_pkg::DATA_W-1:0] data_out,
    output logic [abt_pkg::DATA_W-1:0] data_in,
    output logic transfer_acknowledge_n,
    output logic bus_error_input_n,
    output logic halt_n,
    output logic [abt_pkg::DATA_W-1:0] wr_seen
);
    logic [2:0] mode_reg;
    logic [3:0] cnt;
    logic [1:0] hold;
    logic fault_on;
    logic halt_on;
    logic late;
    logic sel;
    assign sel = !address_strobe_n && !(upper_byte_strobe_n && lower_byte_strobe_n);
    assign bus_error_input_n = !(fault_on || stall_fault);
    assign halt_n = !(halt_on || stall_halt);
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            {mode_reg, cnt, hold, fault_on, halt_on, late} <= 12'h000;
            transfer_acknowledge_n <= 1'b1;
            data_in <= 16'h0000;
            wr_seen <= 16'h0000;
        end else begin
            if (arm) begin
                mode_reg <= mode;
            end
            // released bus keeps changing so stale data never looks valid
            if (transfer_acknowledge_n) begin
                data_in <= ~data_in;
            end
            if (address_strobe_n) begin
                transfer_acknowledge_n <= 1'b1;
            end
            if (sel && transfer_acknowledge_n && !fault_on && !late) begin
                cnt <= (cnt == delay) ? 4'h0 : cnt + 4'h1;
                if (cnt == delay) begin
                    if (mode_reg inside {3'h0, 3'h3, 3'h4, 3'h5}) begin
                        transfer_acknowledge_n <= 1'b0;
                        data_in <= addr_out[15:0] ^ 16'h5A5A;
                        if (!read_write_n) begin
                            wr_seen <= data_out;
                        end
                    end
                    fault_on <= mode_reg inside {3'h1, 3'h2, 3'h3, 3'h6};
                    halt_on <= mode_reg inside {3'h2, 3'h6};
                    late <= mode_reg inside {3'h4, 3'h5};
                end
            end
            // late error one clock after the acknowledge, inside the bound
            if (late) begin
                late <= 1'b0;
                fault_on <= 1'b1;
                halt_on <= (mode_reg == 3'h5);
            end
            if (fault_on) begin
                hold <= hold + 2'h1;
                if (hold == 2'h3) begin
                    fault_on <= 1'b0;
                    mode_reg <= 3'h0;
                    // wrong order on purpose: halt drops with error
                    if (mode_reg == 3'h6) begin
                        halt_on <= 1'b0;
                    end
                end
            end else if (halt_on) begin
                halt_on <= 1'b0;
            end
        end
    end
endmodule // abt_slave

// ---- bench/async_bus_cycle_termination_tb.sv ----
`timescale 1ns/1ps
module async_bus_cycle_termination_tb;
    // ----------------------------------------------------------------
    // stimulus, instances and monitor
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    abt_pkg::abt_req_t req = '0;
    logic arm = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [3:0] delay = 4'h0;
    logic stall_halt = 1'b0;
    logic stall_fault = 1'b0;
    logic req_ready, done_pulse, error_pulse, illegal_pulse, data_oe;
    logic as_n, us_n, ls_n, rw_n, ack_n, fault_n, halt_n;
    logic [abt_pkg::DATA_W-1:0] rdata, data_out, data_in, wr_seen;
    logic [abt_pkg::ADDR_W-1:0] addr_out;
    logic [2:0] res;
    logic prev_as = 1'b1;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_as, t_rw, t_oe, t_ls, as_falls, up_seen, lat;

    initial begin
        forever #5 mclk = ~mclk;
    end

    abt_master u_abt_master (.mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .done_pulse(done_pulse), .error_pulse(error_pulse),
        .illegal_pulse(illegal_pulse), .rdata(rdata), .address_strobe_n(as_n),
        .upper_byte_strobe_n(us_n), .lower_byte_strobe_n(ls_n), .read_write_n(rw_n),
        .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .transfer_acknowledge_n(ack_n), .bus_error_input_n(fault_n), .halt_n(halt_n));

    abt_slave u_abt_slave (.mclk(mclk), .rst(rst), .arm(arm), .mode(mode), .delay(delay),
        .stall_halt(stall_halt), .stall_fault(stall_fault), .address_strobe_n(as_n),
        .upper_byte_strobe_n(us_n), .lower_byte_strobe_n(ls_n), .read_write_n(rw_n),
        .addr_out(addr_out), .data_out(data_out), .data_in(data_in),
        .transfer_acknowledge_n(ack_n), .bus_error_input_n(fault_n), .halt_n(halt_n),
        .wr_seen(wr_seen));

    // outputs are settled at the falling edge
    always @(negedge mclk) begin
        cyc++;
        if (!as_n && prev_as) as_falls++;
        prev_as = as_n;
        if (!as_n && t_as == 0) t_as = cyc;
        if (!rw_n && t_rw == 0) t_rw = cyc;
        if (data_oe && t_oe == 0) t_oe = cyc;
        if (!ls_n && t_ls == 0) t_ls = cyc;
        if (!us_n) up_seen = 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one request, then wait for its termination pulse
    task automatic run_req(input logic w, input logic l, input logic [22:0] a,
                           input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {t_as, t_rw, t_oe, t_ls, as_falls, up_seen} = 192'h0;
        req_valid <= 1'b1;
        req <= '{w, 1'b1, l, a, d};
        #1;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        req_valid <= 1'b0;
        lat = 0;
        res = 3'h0;
        while (res === 3'h0 && lat < 300) begin
            @(posedge mclk);
            #1;
            lat++;
            res = {illegal_pulse, error_pulse, done_pulse};
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_read;
        int l0;
        delay <= 4'h0;
        run_req(1'b0, 1'b1, 23'h000123, 16'h0000);
        l0 = lat;
        check(res, 3'h1);
        check(rdata, 16'h0123 ^ 16'h5A5A);
        check(t_as == t_ls, 1);
        delay <= 4'h5;
        run_req(1'b0, 1'b1, 23'h0007FF, 16'h0000);
        check(lat - l0, 5);
        check(rdata, 16'h07FF ^ 16'h5A5A);
    endtask

    task automatic t_write;
        delay <= 4'h2;
        run_req(1'b1, 1'b1, 23'h000200, 16'hBEEF);
        check(res, 3'h1);
        check(wr_seen, 16'hBEEF);
        check(t_as < t_rw, 1);
        check(t_rw < t_oe, 1);
        check(t_oe < t_ls, 1);
        check(up_seen, 1);
    endtask

    task automatic t_faults;
        for (int m = 1; m <= 6; m++) begin
            @(posedge mclk);
            arm <= 1'b1;
            mode <= m[2:0];
            delay <= 4'h1;
            @(posedge mclk);
            arm <= 1'b0;
            run_req(1'b0, 1'b1, 23'h000040, 16'h0000);
            check(res, (m == 6) ? 3'h4 : (m == 2 || m == 5) ? 3'h1 : 3'h2);
            check(as_falls, (m == 2 || m == 5) ? 2 : 1);
            if (res === 3'h1) check(rdata, 16'h0040 ^ 16'h5A5A);
        end
    endtask

    task automatic t_halt;
        @(posedge mclk);
        stall_halt <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check(req_ready, 0);
        check(as_n, 1);
        @(posedge mclk);
        stall_halt <= 1'b0;
        run_req(1'b0, 1'b1, 23'h000011, 16'h0000);
        check(res, 3'h1);
    endtask

    task automatic t_fault_left;
        @(posedge mclk);
        stall_fault <= 1'b1;
        fork
            run_req(1'b0, 1'b1, 23'h000022, 16'h0000);
            begin
                repeat (12) @(posedge mclk);
                stall_fault <= 1'b0;
            end
        join
        check(res, 3'h2);
    endtask

    // enable low for five edges right after the strobes open
    task automatic t_freeze;
        delay <= 4'h0;
        fork
            run_req(1'b0, 1'b1, 23'h000055, 16'h0000);
            begin
                repeat (3) @(posedge mclk);
                ce <= 1'b0;
                repeat (5) @(posedge mclk);
                ce <= 1'b1;
            end
        join
        check(res, 3'h1);
        // six plus five frozen, less one: the ack is already waiting at resume
        check(lat, 10);
        check(rdata, 16'h0055 ^ 16'h5A5A);
    endtask

    initial begin
        #200000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_read();
        t_write();
        t_faults();
        t_halt();
        t_fault_left();
        t_freeze();
        print_verdict();
    end
endmodule // async_bus_cycle_termination_tb
